// ### inc/aca_pkg.sv
// Purpose: Shared constants of the amplifier configuration register bank
// Assumes: Byte-wide registers reached through the control-bus register port
// Notes: Offsets, field positions, reset values and decode codes live here
//
// Overview of operation
// (RULE_01) Bits 6..4 pick switching rate: 8,10,38,44,48 x fs; reset 110.
// (RULE_02) Bit 2 picks modulator oversampling: 0 gives 64x, 1 gives 128x.
// (RULE_03) Bits 1..0 pick channel phase offset 0/30/45/60 degrees; reset 10.
// (RULE_04) Serial bits 7..6 pick sample rate 44.1/48/96 kHz; 11 reserved.
// (RULE_05) Serial bit 5 picks first or last four slots of eight-slot input.
// (RULE_06) Serial bit 4: zero means 24/32-bit slots, one means 16-bit slots.
// (RULE_07) Serial bit 3 set swaps channel pair 1/2 with pair 3/4.
// (RULE_08) Serial bits 2..0 pick word format; 111 reserved; reset 100.
// (RULE_09) Two-bit state per channel: play, high impedance, mute, load check.
// (RULE_10) Unless inhibited, start load check on leaving high impedance or fault.
// (RULE_11) Reserved bits read zero; reserved codes stored but decode to nothing.

package aca_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] ACA_SWITCH_OFS = 8'h02;
   localparam logic [7:0] ACA_SERIAL_OFS = 8'h03;
   localparam logic [7:0] ACA_CHSTATE_OFS = 8'h04;
   localparam logic [7:0] ACA_SWITCH_RST = 8'h62;
   localparam logic [7:0] ACA_SERIAL_RST = 8'h04;
   localparam logic [7:0] ACA_CHSTATE_RST = 8'h55;
   localparam logic [7:0] ACA_SWITCH_WMASK = 8'h77; // Bits 7 and 3 reserved
   localparam logic [7:0] ACA_UNMAPPED_RD = 8'h00;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int unsigned ACA_PWM_LSB = 4;
   localparam int unsigned ACA_OSR_BIT = 2;
   localparam int unsigned ACA_PHASE_LSB = 0;
   localparam int unsigned ACA_RATE_LSB = 6;
   localparam int unsigned ACA_SLOTGRP_BIT = 5;
   localparam int unsigned ACA_SLOT16_BIT = 4;
   localparam int unsigned ACA_SWAP_BIT = 3;
   localparam int unsigned ACA_FMT_LSB = 0;
   localparam int unsigned ACA_NUM_CH = 4;

   // ----------------------------------------------------------------------
   // Decode values
   // ----------------------------------------------------------------------
   localparam logic [5:0] ACA_MULT_8 = 6'h08;
   localparam logic [5:0] ACA_MULT_10 = 6'h0A;
   localparam logic [5:0] ACA_MULT_38 = 6'h26;
   localparam logic [5:0] ACA_MULT_44 = 6'h2C;
   localparam logic [5:0] ACA_MULT_48 = 6'h30;
   localparam logic [5:0] ACA_DEG_0 = 6'h00;
   localparam logic [5:0] ACA_DEG_30 = 6'h1E;
   localparam logic [5:0] ACA_DEG_45 = 6'h2D;
   localparam logic [5:0] ACA_DEG_60 = 6'h3C;
   localparam logic [4:0] ACA_RJ_24 = 5'h18;
   localparam logic [4:0] ACA_RJ_20 = 5'h14;
   localparam logic [4:0] ACA_RJ_18 = 5'h12;
   localparam logic [4:0] ACA_RJ_16 = 5'h10;
   localparam logic [1:0] ACA_RATE_RSVD = 2'h3;
   localparam logic [2:0] ACA_FMT_I2S = 3'h4;
   localparam logic [2:0] ACA_FMT_LJ = 3'h5;
   localparam logic [2:0] ACA_FMT_DSP = 3'h6;

   // Channel operating states
   typedef enum logic [1:0] {
      ACA_ST_PLAY = 2'h0,
      ACA_ST_HIZ = 2'h1,
      ACA_ST_MUTE = 2'h2,
      ACA_ST_CHECK = 2'h3
   } aca_chst_e;

endpackage : aca_pkg

// ### src/aca_config_regs.sv
// Purpose: Switching, serial port and channel state configuration registers
// Assumes: Register port driven by the control-bus front end on mclk_in
// Notes: Switching and serial decodes lag the register contents by one clock; channel state outputs change with the register

`timescale 1ns/1ps

module aca_config_regs
   import aca_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic nrst_in,
   // Register port from the control-bus front end
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   // Load check control from the diagnostic side
   input wire logic auto_check_inhibit_in,
   input wire logic [ACA_NUM_CH-1:0] ch_fault_in,
   // Switching setup
   output logic [5:0] pwm_mult_out,
   output logic pwm_code_ok_out,
   output logic osr_128_out,
   output logic [5:0] phase_deg_out,
   // Serial audio port setup
   output logic [1:0] rate_code_out,
   output logic rate_ok_out,
   output logic slot_group_last_out,
   output logic slot_16bit_out,
   output logic pair_swap_out,
   output logic [4:0] fmt_rj_bits_out,
   output logic fmt_i2s_out,
   output logic fmt_lj_out,
   output logic fmt_dsp_out,
   // Channel states, channel 1 in bit 0
   output logic [ACA_NUM_CH-1:0] ch_play_out,
   output logic [ACA_NUM_CH-1:0] ch_hiz_out,
   output logic [ACA_NUM_CH-1:0] ch_mute_out,
   output logic [ACA_NUM_CH-1:0] ch_check_out,
   output logic [ACA_NUM_CH-1:0] auto_check_start_out
);

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [7:0] switch_cfg_r, switch_cfg_nxt;
   logic [7:0] serial_cfg_r, serial_cfg_nxt;
   logic [7:0] chstate_cfg_r, chstate_cfg_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic rd_valid_r, rd_valid_nxt;

   // Write decode; unmapped writes fall through untouched
   always_comb begin
      switch_cfg_nxt = switch_cfg_r;
      serial_cfg_nxt = serial_cfg_r;
      chstate_cfg_nxt = chstate_cfg_r;
      if (wr_en_in) begin
         unique case (addr_in)
            ACA_SWITCH_OFS: begin
               switch_cfg_nxt = wdata_in & ACA_SWITCH_WMASK; // see RULE_11
            end
            ACA_SERIAL_OFS: begin
               serial_cfg_nxt = wdata_in; // Reserved codes kept, see RULE_11
            end
            ACA_CHSTATE_OFS: begin
               chstate_cfg_nxt = wdata_in; // see RULE_09
            end
            default: begin
            end
         endcase
      end
   end

   // Read mux; unmapped addresses answer zero
   always_comb begin
      rd_valid_nxt = rd_en_in;
      rd_data_nxt = ACA_UNMAPPED_RD;
      if (rd_en_in) begin
         unique case (addr_in)
            ACA_SWITCH_OFS: begin
               rd_data_nxt = switch_cfg_r & ACA_SWITCH_WMASK; // see RULE_11
            end
            ACA_SERIAL_OFS: begin
               rd_data_nxt = serial_cfg_r;
            end
            ACA_CHSTATE_OFS: begin
               rd_data_nxt = chstate_cfg_r;
            end
            default: begin
               rd_data_nxt = ACA_UNMAPPED_RD;
            end
         endcase
      end
   end

   // Register bank flops
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         switch_cfg_r <= ACA_SWITCH_RST; // see RULE_01
         serial_cfg_r <= ACA_SERIAL_RST; // see RULE_08
         chstate_cfg_r <= ACA_CHSTATE_RST; // see RULE_09
         rd_data_r <= ACA_UNMAPPED_RD;
         rd_valid_r <= 1'b0;
      end else begin
         switch_cfg_r <= switch_cfg_nxt;
         serial_cfg_r <= serial_cfg_nxt;
         chstate_cfg_r <= chstate_cfg_nxt;
         rd_data_r <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
      end
   end

   assign rd_data_out = rd_data_r;
   assign rd_valid_out = rd_valid_r;

   // ----------------------------------------------------------------------
   // Switching and serial port decode
   // ----------------------------------------------------------------------
   logic [5:0] pwm_mult_r, pwm_mult_nxt;
   logic pwm_ok_r, pwm_ok_nxt;
   logic [5:0] phase_r, phase_nxt;
   logic [4:0] rj_bits_r, rj_bits_nxt;
   logic [2:0] fmt_flags_r, fmt_flags_nxt;
   logic [6:0] serial_dec_r, serial_dec_nxt;

   // Reserved switching codes give zero and a low ok flag rather than a guess
   always_comb begin
      pwm_ok_nxt = 1'b1;
      unique case (switch_cfg_r[ACA_PWM_LSB +: 3]) // see RULE_01
         3'h0: pwm_mult_nxt = ACA_MULT_8;
         3'h1: pwm_mult_nxt = ACA_MULT_10;
         3'h5: pwm_mult_nxt = ACA_MULT_38;
         3'h6: pwm_mult_nxt = ACA_MULT_44;
         3'h7: pwm_mult_nxt = ACA_MULT_48;
         default: begin
            pwm_mult_nxt = 6'h00; // see RULE_11
            pwm_ok_nxt = 1'b0;
         end
      endcase
      unique case (switch_cfg_r[ACA_PHASE_LSB +: 2]) // see RULE_03
         2'h0: phase_nxt = ACA_DEG_0;
         2'h1: phase_nxt = ACA_DEG_30;
         2'h2: phase_nxt = ACA_DEG_45;
         default: phase_nxt = ACA_DEG_60;
      endcase
      rj_bits_nxt = 5'h00;
      unique case (serial_cfg_r[ACA_FMT_LSB +: 3]) // see RULE_08
         3'h0: rj_bits_nxt = ACA_RJ_24;
         3'h1: rj_bits_nxt = ACA_RJ_20;
         3'h2: rj_bits_nxt = ACA_RJ_18;
         3'h3: rj_bits_nxt = ACA_RJ_16;
         default: rj_bits_nxt = 5'h00;
      endcase
      fmt_flags_nxt[0] = serial_cfg_r[ACA_FMT_LSB +: 3] == ACA_FMT_I2S;
      fmt_flags_nxt[1] = serial_cfg_r[ACA_FMT_LSB +: 3] == ACA_FMT_LJ;
      fmt_flags_nxt[2] = serial_cfg_r[ACA_FMT_LSB +: 3] == ACA_FMT_DSP;
      serial_dec_nxt[1:0] = serial_cfg_r[ACA_RATE_LSB +: 2]; // see RULE_04
      serial_dec_nxt[2] = serial_cfg_r[ACA_RATE_LSB +: 2] != ACA_RATE_RSVD;
      serial_dec_nxt[3] = serial_cfg_r[ACA_SLOTGRP_BIT]; // see RULE_05
      serial_dec_nxt[4] = serial_cfg_r[ACA_SLOT16_BIT]; // see RULE_06
      serial_dec_nxt[5] = serial_cfg_r[ACA_SWAP_BIT]; // see RULE_07
      serial_dec_nxt[6] = switch_cfg_r[ACA_OSR_BIT]; // see RULE_02
   end

   // Decode flops; reset values match the register reset decode
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pwm_mult_r <= ACA_MULT_44;
         pwm_ok_r <= 1'b1;
         phase_r <= ACA_DEG_45;
         rj_bits_r <= 5'h00;
         fmt_flags_r <= 3'h1;
         serial_dec_r <= 7'h04;
      end else begin
         pwm_mult_r <= pwm_mult_nxt;
         pwm_ok_r <= pwm_ok_nxt;
         phase_r <= phase_nxt;
         rj_bits_r <= rj_bits_nxt;
         fmt_flags_r <= fmt_flags_nxt;
         serial_dec_r <= serial_dec_nxt;
      end
   end

   assign pwm_mult_out = pwm_mult_r;
   assign pwm_code_ok_out = pwm_ok_r;
   assign phase_deg_out = phase_r;
   assign fmt_rj_bits_out = rj_bits_r;
   assign fmt_i2s_out = fmt_flags_r[0];
   assign fmt_lj_out = fmt_flags_r[1];
   assign fmt_dsp_out = fmt_flags_r[2];
   assign rate_code_out = serial_dec_r[1:0];
   assign rate_ok_out = serial_dec_r[2];
   assign slot_group_last_out = serial_dec_r[3];
   assign slot_16bit_out = serial_dec_r[4];
   assign pair_swap_out = serial_dec_r[5];
   assign osr_128_out = serial_dec_r[6];

   // ----------------------------------------------------------------------
   // Per-channel state decode and automatic load check
   // ----------------------------------------------------------------------
   logic [ACA_NUM_CH-1:0] play_r, play_nxt;
   logic [ACA_NUM_CH-1:0] hiz_r, hiz_nxt;
   logic [ACA_NUM_CH-1:0] mute_r, mute_nxt;
   logic [ACA_NUM_CH-1:0] check_r, check_nxt;
   logic [ACA_NUM_CH-1:0] start_r, start_nxt;

   // Leaving high impedance is seen on the stored field, so a rewrite of
   // the same value starts nothing
   for (genvar ch = 0; ch < ACA_NUM_CH; ch++) begin : g_ch
      logic [1:0] cur_st;
      logic [1:0] new_st;
      assign cur_st = chstate_cfg_r[7-2*ch -: 2];
      assign new_st = chstate_cfg_nxt[7-2*ch -: 2];
      always_comb begin
         play_nxt[ch] = new_st == ACA_ST_PLAY; // see RULE_09
         hiz_nxt[ch] = new_st == ACA_ST_HIZ;
         mute_nxt[ch] = new_st == ACA_ST_MUTE;
         check_nxt[ch] = new_st == ACA_ST_CHECK;
         start_nxt[ch] = !auto_check_inhibit_in &&
            ((cur_st == ACA_ST_HIZ && new_st != ACA_ST_HIZ) ||
             ch_fault_in[ch]); // see RULE_10
      end
   end

   // Channel flops; all channels start in high impedance
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         play_r <= '0;
         hiz_r <= '1;
         mute_r <= '0;
         check_r <= '0;
         start_r <= '0;
      end else begin
         play_r <= play_nxt;
         hiz_r <= hiz_nxt;
         mute_r <= mute_nxt;
         check_r <= check_nxt;
         start_r <= start_nxt;
      end
   end

   assign ch_play_out = play_r;
   assign ch_hiz_out = hiz_r;
   assign ch_mute_out = mute_r;
   assign ch_check_out = check_r;
   assign auto_check_start_out = start_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   a_pwm_code_map: assert property ( // see RULE_01
      (wr_en_in && addr_in == ACA_SWITCH_OFS && wdata_in[6:4] == 3'h0)
      |=> ##1 (pwm_mult_out == ACA_MULT_8))
      else $error("switching rate code 000 did not give 8");

   a_pwm_rsvd_code: assert property ( // see RULE_11
      (switch_cfg_r[6:4] inside {3'h2, 3'h3, 3'h4}) |=> !pwm_code_ok_out)
      else $error("reserved switching code decoded as valid");

   a_osr_follow: assert property ( // see RULE_02
      osr_128_out == $past(switch_cfg_r[ACA_OSR_BIT]))
      else $error("oversampling select does not follow register");

   a_phase_map: assert property ( // see RULE_03
      (switch_cfg_r[1:0] == 2'h2) |=> (phase_deg_out == ACA_DEG_45))
      else $error("phase code 10 did not give 45 degrees");

   a_rate_rsvd: assert property ( // see RULE_04
      rate_ok_out == ($past(serial_cfg_r[7:6]) != ACA_RATE_RSVD))
      else $error("sample rate valid flag wrong");

   a_serial_bits: assert property ( // see RULE_05
      {slot_group_last_out, slot_16bit_out, pair_swap_out} ==
      $past(serial_cfg_r[5:3]))
      else $error("slot group, slot size or pair swap wrong");

   a_fmt_onehot: assert property ( // see RULE_08
      $onehot0({fmt_i2s_out, fmt_lj_out, fmt_dsp_out, fmt_rj_bits_out != 5'h00}))
      else $error("more than one word format active");

   a_rd_zero_rsvd: assert property ( // see RULE_11
      (rd_en_in && addr_in == ACA_SWITCH_OFS) |=> !rd_data_out[7] && !rd_data_out[3])
      else $error("reserved switching bits read nonzero");

   a_chan_onehot: assert property ( // see RULE_09
      ((ch_play_out | ch_hiz_out | ch_mute_out | ch_check_out) == '1) &&
      ($countones({ch_play_out, ch_hiz_out, ch_mute_out, ch_check_out}) == ACA_NUM_CH))
      else $error("channel without an operating state");

   a_check_start: assert property ( // see RULE_10
      (!auto_check_inhibit_in && wr_en_in && addr_in == ACA_CHSTATE_OFS &&
       chstate_cfg_r[7:6] == ACA_ST_HIZ && wdata_in[7:6] == ACA_ST_PLAY)
      |=> auto_check_start_out[0] ##1 ch_play_out[0])
      else $error("leaving high impedance did not start load check");

   a_check_inhibit: assert property ( // see RULE_10
      auto_check_inhibit_in |=> auto_check_start_out == '0)
      else $error("load check started while inhibited");

   c_write_switch: cover property (wr_en_in && addr_in == ACA_SWITCH_OFS);
   c_read_serial: cover property (rd_en_in && addr_in == ACA_SERIAL_OFS ##1 rd_valid_out);
   c_auto_start: cover property (auto_check_start_out != '0);
   c_fault_start: cover property (ch_fault_in[3] && !auto_check_inhibit_in);

endmodule : aca_config_regs

// ### sim/aca_host_model.sv
// Purpose: Host side of the register port, standing in for the control-bus front end
// Assumes: Single-byte strobes, answer one clock after a read strobe
// Notes: Drives on the falling edge; released lines show inverted data, not a stale copy

`timescale 1ns/1ps

module aca_host_model (
   // Clock
   input wire logic mclk_in,
   // Answer from the register bank
   input wire logic [7:0] rd_data_in,
   input wire logic rd_valid_in,
   // Request toward the register bank
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out
);

   // ----------------------------------------------------------------------
   // Idle levels
   // ----------------------------------------------------------------------
   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end

   // One write strobe, held across exactly one rising edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      wr_en_out = 1'b1;
      addr_out = a;
      wdata_out = d;
      @(negedge mclk_in);
      wr_en_out = 1'b0;
      addr_out = ~a; // Released lines must not mimic the last value
      wdata_out = ~d;
   endtask : write_reg

   // One read strobe, answer awaited for a bounded number of cycles
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
      int n;
      @(negedge mclk_in);
      rd_en_out = 1'b1;
      addr_out = a;
      @(negedge mclk_in);
      rd_en_out = 1'b0;
      addr_out = ~a;
      ok = 1'b0;
      d = 8'h00;
      for (n = 0; n < 4 && !ok; n++) begin
         if (rd_valid_in === 1'b1) begin
            d = rd_data_in;
            ok = 1'b1;
         end else begin
            @(negedge mclk_in);
         end
      end
   endtask : read_reg

endmodule : aca_host_model

// ### sim/amp_config_registers_test.sv
// Purpose: Self-checking bench of the amplifier configuration register bank
// Assumes: Switching and serial decodes settle one clock after the register is written, channel states on the write edge
// Notes: Inputs change on the falling edge so no race with the sampling edge

`timescale 1ns/1ps

module amp_config_registers_test;
   import aca_pkg::*;

   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic inhibit = 1'b0;
   logic [3:0] fault = 4'h0;
   logic wr_en, rd_en, rd_valid, pwm_ok, osr_128, rate_ok, grp_last, slot16, swap;
   logic fmt_i2s, fmt_lj, fmt_dsp;
   logic [7:0] addr, wdata, rd_data;
   logic [5:0] pwm_mult, phase_deg;
   logic [1:0] rate_code;
   logic [4:0] rj_bits;
   logic [3:0] ch_play, ch_hiz, ch_mute, ch_check, start;
   int n_mismatch = 0;
   int check_count = 0;
   // Expected decodes per code
   logic [7:0] mult_t [8] = '{8'h08, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h26, 8'h2C, 8'h30};
   logic [7:0] phase_t [4] = '{8'h00, 8'h1E, 8'h2D, 8'h3C};
   logic [7:0] rj_t [8] = '{8'h18, 8'h14, 8'h12, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};

   // ----------------------------------------------------------------------
   // Clock, design and host
   // ----------------------------------------------------------------------
   always #5 mclk = ~mclk;

   aca_config_regs dut (.mclk_in(mclk), .nrst_in(nrst), .wr_en_in(wr_en), .rd_en_in(rd_en),
      .addr_in(addr), .wdata_in(wdata), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
      .auto_check_inhibit_in(inhibit), .ch_fault_in(fault), .pwm_mult_out(pwm_mult),
      .pwm_code_ok_out(pwm_ok), .osr_128_out(osr_128), .phase_deg_out(phase_deg),
      .rate_code_out(rate_code), .rate_ok_out(rate_ok), .slot_group_last_out(grp_last),
      .slot_16bit_out(slot16), .pair_swap_out(swap), .fmt_rj_bits_out(rj_bits),
      .fmt_i2s_out(fmt_i2s), .fmt_lj_out(fmt_lj), .fmt_dsp_out(fmt_dsp),
      .ch_play_out(ch_play), .ch_hiz_out(ch_hiz), .ch_mute_out(ch_mute),
      .ch_check_out(ch_check), .auto_check_start_out(start));

   aca_host_model host (.mclk_in(mclk), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
      .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));

   // ----------------------------------------------------------------------
   // Compare, access and report tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      bit ok;
      host.read_reg(a, d, ok);
      if (!ok) begin
         n_mismatch++;
         $display("ERROR at %0t: no read answer", $time);
         summarize();
      end else begin
         chk(d, exp, "read data");
      end
   endtask : rd_chk

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : summarize

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      logic [7:0] d;
      logic [2:0] c;
      repeat (16) @(negedge mclk);
      nrst = 1'b1;
      chk({2'h0, pwm_mult}, 8'h2C, "reset mult");
      chk({7'h00, osr_128}, 8'h00, "reset osr");
      chk({2'h0, phase_deg}, 8'h2D, "reset phase");
      chk({6'h00, rate_code}, 8'h00, "reset rate");
      chk({5'h00, fmt_i2s, fmt_lj, fmt_dsp}, 8'h04, "reset format");
      chk({4'h0, ch_hiz}, 8'h0F, "reset states");
      rd_chk(8'h02, 8'h62);
      rd_chk(8'h03, 8'h04);
      rd_chk(8'h04, 8'h55);
      rd_chk(8'h05, 8'h00);
      // Every switching code, reserved bits written as ones
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         d = {1'b1, c, 1'b1, c[0], c[1:0]};
         host.write_reg(8'h02, d);
         @(negedge mclk);
         chk({2'h0, pwm_mult}, mult_t[i], "mult");
         chk({7'h00, pwm_ok}, {7'h00, (c < 3'h2 || c > 3'h4)}, "mult ok");
         chk({7'h00, osr_128}, {7'h00, c[0]}, "osr");
         chk({2'h0, phase_deg}, phase_t[c[1:0]], "phase");
         rd_chk(8'h02, d & 8'h77);
      end
      // Every serial port code, each flag in both states
      for (int i = 0; i < 8; i++) begin
         c = i[2:0];
         d = {c[1:0], c[0], c[1], c[2], c};
         host.write_reg(8'h03, d);
         @(negedge mclk);
         chk({6'h00, rate_code}, {6'h00, c[1:0]}, "rate");
         chk({7'h00, rate_ok}, {7'h00, c[1:0] != 2'h3}, "rate ok");
         chk({7'h00, grp_last}, {7'h00, c[0]}, "slot group");
         chk({7'h00, slot16}, {7'h00, c[1]}, "slot size");
         chk({7'h00, swap}, {7'h00, c[2]}, "pair swap");
         chk({3'h0, rj_bits}, rj_t[i], "rj width");
         chk({5'h00, fmt_i2s, fmt_lj, fmt_dsp}, {5'h00, c == 3'h4, c == 3'h5, c == 3'h6},
            "format flags");
         rd_chk(8'h03, d);
      end
      // Channels leave high impedance: play, stay, mute, load check
      host.write_reg(8'h04, 8'h1B);
      chk({4'h0, start}, 8'h0D, "auto start");
      @(negedge mclk);
      chk({4'h0, start}, 8'h00, "start pulse end");
      chk({ch_check, ch_mute}, 8'h84, "check mute");
      chk({ch_hiz, ch_play}, 8'h21, "hiz play");
      host.write_reg(8'h04, 8'h55);
      chk({4'h0, start}, 8'h00, "enter hiz");
      inhibit = 1'b1;
      host.write_reg(8'h04, 8'h00);
      chk({4'h0, start}, 8'h00, "inhibited leave");
      fault = 4'h8;
      @(negedge mclk);
      fault = 4'h0;
      chk({4'h0, start}, 8'h00, "inhibited fault");
      inhibit = 1'b0;
      fault = 4'h4;
      @(negedge mclk);
      fault = 4'h0;
      chk({4'h0, start}, 8'h04, "fault start");
      // Unmapped write leaves the channel state register alone
      host.write_reg(8'h05, 8'hFF);
      rd_chk(8'h04, 8'h00);
      // Mid-run reset must bring back the defaults, not keep the written values
      nrst = 1'b0;
      repeat (2) @(negedge mclk);
      nrst = 1'b1;
      chk({4'h0, ch_hiz}, 8'h0F, "reset again states");
      chk({2'h0, pwm_mult}, 8'h2C, "reset again mult");
      rd_chk(8'h02, 8'h62);
      rd_chk(8'h04, 8'h55);
      summarize();
   end

endmodule : amp_config_registers_test
